// file: hw/prer_top.sv
/*
  Protocol error reporter: records device protocol errors in the error log,
  queues one report message per unmasked logged error toward the host error agent,
  poisons affected data, flags unsafe links and steers transport faults to
  the standard advanced error reporting path.
  Assumes all inputs come from logic on CLOCK_I, one event per cycle on
  ERR_VALID_I, and a message sink that holds MSG_READY_I under its own rules.
*/
`timescale 1ns/1ps
`default_nettype none

// Functional notes
// - log every produced or consumed protocol error
// - send report to sink agent identifier
// - poison uncorrected data errors when able
// - check-code and decode failures both poison
// - unpoisonable unsafe error sets unsafe flag
// - producer that consumes also obeys consumer duty
// - transport faults go to advanced error path
// - poison confined to one cache line
// - consumer never acts on erroneous data
// - host mask suppresses report messages
// - report revision field carries one
// - keep first error per severity, flag others
module prer_top
  import prer_pkg::*;
#(
  parameter int ADDR_W = PRER_ADDR_W_DEF
) (
  input wire logic CLOCK_I,
  input wire logic RESET_I,
  input wire logic ERR_VALID_I,
  input wire logic ERR_TRANSPORT_I,
  input wire logic ERR_UNCORR_I,
  input wire logic ERR_ECC_I,
  input wire logic ERR_DECODE_I,
  input wire logic ERR_PRODUCED_I,
  input wire logic ERR_CONSUMED_I,
  input wire logic ERR_POISON_ABLE_I,
  input wire logic ERR_UNSAFE_I,
  input wire logic [PRER_SRC_ID_W-1:0] ERR_SRC_ID_I,
  input wire logic [ADDR_W-1:0] ERR_ADDR_I,
  input wire logic REPORT_MASK_I,
  input wire logic [PRER_AGENT_ID_W-1:0] ERROR_SINK_AGENT_ID_I,
  input wire logic LOG_CLEAR_I,
  input wire logic MSG_READY_I,
  output logic LOG_WR_O,
  output logic LOG_VALID_O,
  output logic LOG_UNCORR_O,
  output logic LOG_UNSAFE_O,
  output logic LOG_CONSUMED_O,
  output logic LOG_SEVERAL_O,
  output logic [PRER_SRC_ID_W-1:0] LOG_SRC_ID_O,
  output logic [ADDR_W-1:0] LOG_ADDR_O,
  output logic MSG_VALID_O,
  output logic [PRER_AGENT_ID_W-1:0] MSG_DEST_ID_O,
  output logic [7:0] MSG_REVISION_O,
  output logic MSG_SEVERAL_O,
  output logic MSG_UNCORR_O,
  output logic MSG_UNSAFE_O,
  output logic [PRER_SRC_ID_W-1:0] MSG_SRC_ID_O,
  output logic [ADDR_W-1:0] MSG_ADDR_O,
  output logic POISON_O,
  output logic [ADDR_W-1:0] POISON_ADDR_O,
  output logic DISCARD_O,
  output logic AER_REPORT_O,
  output logic AER_UNCORR_O
);

  // ----------------------------------------------------------------------
  // elaboration checks
  // ----------------------------------------------------------------------
  if (ADDR_W <= PRER_GRANULE_LG) begin : g_bad_addr_w
    $error("ADDR_W must exceed the poison granule width");
  end

  // ----------------------------------------------------------------------
  // state
  // ----------------------------------------------------------------------
  typedef struct packed {
    prer_state_e state;
    logic log_valid;
    logic log_uncorr;
    logic log_unsafe;
    logic log_consumed;
    logic several;
    logic [PRER_SRC_ID_W-1:0] log_src;
    logic [ADDR_W-1:0] log_addr;
    logic masked;
    logic [PRER_AGENT_ID_W-1:0] sink;
    logic log_wr;
    logic msg_valid;
    logic [7:0] msg_rev;
    logic msg_several;
    logic msg_uncorr;
    logic msg_unsafe;
    logic [PRER_SRC_ID_W-1:0] msg_src;
    logic [ADDR_W-1:0] msg_addr;
    logic poison;
    logic [ADDR_W-1:0] poison_addr;
    logic discard;
    logic aer;
    logic aer_uncorr;
  } prer_regs_s;

  prer_regs_s s_q;
  prer_regs_s s_d;

  logic idle_w;
  logic err_real_w;
  logic data_hit_w;
  logic clear_w;
  logic held_w;
  logic accept_w;
  logic unsafe_w;

  assign idle_w = (s_q.state == PRER_IDLE);
  // transport faults never enter the protocol record
  assign err_real_w = ERR_VALID_I && !ERR_TRANSPORT_I;
  assign data_hit_w = ERR_UNCORR_I && (ERR_ECC_I || ERR_DECODE_I);
  // clearing mid-report would tear the message, so a clear outside idle is dropped
  assign clear_w = LOG_CLEAR_I && idle_w;
  assign held_w = s_q.log_valid && !clear_w;
  // an uncorrected error outranks a held corrected one
  assign accept_w = idle_w && err_real_w && (!held_w || (ERR_UNCORR_I && !s_q.log_uncorr));
  assign unsafe_w = data_hit_w && !ERR_POISON_ABLE_I && ERR_UNSAFE_I;

  // ----------------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------------
  always_comb begin
    s_d = s_q;
    s_d.log_wr = 1'b0;
    s_d.poison = 1'b0;
    s_d.discard = 1'b0;
    s_d.aer = 1'b0;

    if (clear_w) begin
      s_d.log_valid = 1'b0;
      s_d.several = 1'b0;
    end
    // held_w is low in a clear cycle, so a same-cycle event is logged, not flagged
    if (err_real_w && held_w) begin
      s_d.several = 1'b1;
    end

    if (ERR_VALID_I && ERR_TRANSPORT_I) begin
      s_d.aer = 1'b1;
      s_d.aer_uncorr = ERR_UNCORR_I;
    end

    if (err_real_w && data_hit_w && ERR_PRODUCED_I && ERR_POISON_ABLE_I) begin
      s_d.poison = 1'b1;
      // only the line holding the fault is marked
      s_d.poison_addr = {ERR_ADDR_I[ADDR_W-1:PRER_GRANULE_LG], {PRER_GRANULE_LG{1'b0}}};
    end

    // a producer that also consumes gets discard, and poison only when the data error is poisonable
    if (err_real_w && ERR_CONSUMED_I && ERR_UNCORR_I) begin
      s_d.discard = 1'b1;
    end

    if (accept_w) begin
      s_d.log_wr = 1'b1;
      s_d.log_valid = 1'b1;
      s_d.log_uncorr = ERR_UNCORR_I;
      s_d.log_unsafe = unsafe_w;
      s_d.log_consumed = ERR_CONSUMED_I;
      s_d.log_src = ERR_SRC_ID_I;
      s_d.log_addr = ERR_ADDR_I;
      s_d.masked = REPORT_MASK_I;
      s_d.sink = ERROR_SINK_AGENT_ID_I;
    end

    unique case (s_q.state)
      PRER_IDLE: begin
        if (accept_w) begin
          s_d.state = PRER_LOG;
        end
      end
      PRER_LOG: begin
        if (s_q.masked) begin
          s_d.state = PRER_IDLE;
        end else begin
          // snapshot the settled log so the message cannot drift
          s_d.msg_valid = 1'b1;
          s_d.msg_rev = PRER_REPORT_REVISION;
          s_d.msg_several = s_q.several;
          s_d.msg_uncorr = s_q.log_uncorr;
          s_d.msg_unsafe = s_q.log_unsafe;
          s_d.msg_src = s_q.log_src;
          s_d.msg_addr = s_q.log_addr;
          s_d.state = PRER_SEND;
        end
      end
      PRER_SEND: begin
        if (MSG_READY_I) begin
          s_d.msg_valid = 1'b0;
          s_d.state = PRER_IDLE;
        end
      end
      default: begin
        s_d.state = PRER_IDLE;
      end
    endcase
  end

  always_ff @(posedge CLOCK_I) begin
    if (RESET_I) begin
      s_q <= '0;
      s_q.state <= PRER_STATE_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ----------------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------------
  assign LOG_WR_O = s_q.log_wr;
  assign LOG_VALID_O = s_q.log_valid;
  assign LOG_UNCORR_O = s_q.log_uncorr;
  assign LOG_UNSAFE_O = s_q.log_unsafe;
  assign LOG_CONSUMED_O = s_q.log_consumed;
  assign LOG_SEVERAL_O = s_q.several;
  assign LOG_SRC_ID_O = s_q.log_src;
  assign LOG_ADDR_O = s_q.log_addr;
  assign MSG_VALID_O = s_q.msg_valid;
  assign MSG_DEST_ID_O = s_q.sink;
  assign MSG_REVISION_O = s_q.msg_rev;
  assign MSG_SEVERAL_O = s_q.msg_several;
  assign MSG_UNCORR_O = s_q.msg_uncorr;
  assign MSG_UNSAFE_O = s_q.msg_unsafe;
  assign MSG_SRC_ID_O = s_q.msg_src;
  assign MSG_ADDR_O = s_q.msg_addr;
  assign POISON_O = s_q.poison;
  assign POISON_ADDR_O = s_q.poison_addr;
  assign DISCARD_O = s_q.discard;
  assign AER_REPORT_O = s_q.aer;
  assign AER_UNCORR_O = s_q.aer_uncorr;

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge CLOCK_I);
  endclocking
  default disable iff (RESET_I);

  sequence log_step;
    s_q.log_wr && !s_q.masked;
  endsequence

  sequence send_step;
    s_q.msg_valid && s_q.msg_src == $past(s_q.log_src);
  endsequence

  a_log_first_entry: assert property (
    accept_w |=> s_q.log_wr && s_q.log_src == $past(ERR_SRC_ID_I) && s_q.log_valid)
    else $error("accepted error not logged");

  a_report_queued: assert property (
    log_step |=> send_step)
    else $error("unmasked log write not followed by report");

  a_msg_after_log: assert property (
    $rose(s_q.msg_valid) |-> $past(s_q.log_wr, 2) || $past(s_q.state) == PRER_LOG)
    else $error("report raised without preceding log write");

  a_msg_held_stable: assert property (
    s_q.msg_valid && !MSG_READY_I |=> s_q.msg_valid && $stable(s_q.msg_addr)
      && $stable(s_q.msg_several))
    else $error("report changed before acceptance");

  a_mask_silences: assert property (
    s_q.log_wr && s_q.masked |=> !s_q.msg_valid ##1 !s_q.msg_valid)
    else $error("masked error produced a report");

  a_revision_one: assert property (
    s_q.msg_valid |-> s_q.msg_rev == 8'h01)
    else $error("report revision not one");

  a_poison_data: assert property (
    err_real_w && ERR_UNCORR_I && ERR_DECODE_I && ERR_PRODUCED_I && ERR_POISON_ABLE_I
      |=> s_q.poison)
    else $error("decode data error not poisoned");

  a_poison_granule: assert property (
    s_q.poison |-> s_q.poison_addr[PRER_GRANULE_LG-1:0] == '0
      && s_q.poison_addr[ADDR_W-1:PRER_GRANULE_LG]
         == $past(ERR_ADDR_I[ADDR_W-1:PRER_GRANULE_LG]))
    else $error("poison reached beyond one line");

  a_unsafe_flag: assert property (
    accept_w && ERR_UNCORR_I && ERR_ECC_I && !ERR_POISON_ABLE_I && ERR_UNSAFE_I
      |=> s_q.log_unsafe && !s_q.poison)
    else $error("unsafe flag missing");

  a_transport_aside: assert property (
    ERR_VALID_I && ERR_TRANSPORT_I |=> s_q.aer && !s_q.log_wr)
    else $error("transport fault misrouted");

  a_consumer_discard: assert property (
    err_real_w && ERR_CONSUMED_I && ERR_UNCORR_I |=> s_q.discard)
    else $error("consumed error data not discarded");

  a_several_errors: assert property (
    err_real_w && held_w && !(ERR_UNCORR_I && !s_q.log_uncorr)
      |=> s_q.several && !s_q.log_wr && $stable(s_q.log_src))
    else $error("second error overwrote log");

endmodule : prer_top

`default_nettype wire

// file: shared/prer_pkg.sv
/*
  Constants and types shared by the protocol error reporter.
  Assumes nothing of its surroundings; imported whole by the reporter module.
*/
`default_nettype none

package prer_pkg;

  // ----------------------------------------------------------------------
  // message and record constants
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRER_REPORT_REVISION = 8'h01;
  localparam int PRER_SRC_ID_W = 8;
  localparam int PRER_AGENT_ID_W = 6;
  // log2 of the poison granule in bytes: one 64 byte cache line
  localparam int PRER_GRANULE_LG = 6;
  localparam int PRER_ADDR_W_DEF = 64;

  // ----------------------------------------------------------------------
  // sequencer states, gray along idle -> log -> send
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PRER_IDLE = 2'b00,
    PRER_LOG = 2'b01,
    PRER_SEND = 2'b11
  } prer_state_e;

  localparam prer_state_e PRER_STATE_RST = PRER_IDLE;

endpackage : prer_pkg

`default_nettype wire

// file: testbench/prer_sink_model.sv
/*
  Host error agent stand-in: takes report messages after a chosen wait.
  Assumes a message valid that holds until taken, all on one clock.
*/
`timescale 1ns/1ps
`default_nettype none

module prer_sink_model (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic msg_valid_i,
  input wire logic [3:0] delay_i,
  output logic msg_ready_o,
  output logic [7:0] count_o
);
  logic [3:0] wait_q;

  // ready lasts one cycle so a second message is never taken early
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wait_q <= 4'h0;
      msg_ready_o <= 1'b0;
      count_o <= 8'h00;
    end else begin
      msg_ready_o <= 1'b0;
      if (msg_valid_i && !msg_ready_o) begin
        if (wait_q >= delay_i) begin
          msg_ready_o <= 1'b1;
          wait_q <= 4'h0;
          count_o <= count_o + 8'h01;
        end else begin
          wait_q <= wait_q + 4'h1;
        end
      end
    end
  end
endmodule : prer_sink_model

`default_nettype wire

// file: testbench/testbench.sv
/*
  Self-checking bench for the protocol error reporter.
  Assumes prer_top at ADDR_W 64 and the sink model on its message side.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  logic CLOCK_I = '0;
  logic RESET_I = '1;
  logic ERR_VALID_I = '0, ERR_TRANSPORT_I = '0, ERR_UNCORR_I = '0, ERR_ECC_I = '0;
  logic ERR_DECODE_I = '0, ERR_PRODUCED_I = '0, ERR_CONSUMED_I = '0, ERR_UNSAFE_I = '0;
  logic ERR_POISON_ABLE_I = '0, REPORT_MASK_I = '0, LOG_CLEAR_I = '0;
  logic [7:0] ERR_SRC_ID_I = '0;
  logic [63:0] ERR_ADDR_I = '0;
  logic [5:0] ERROR_SINK_AGENT_ID_I = '0;
  logic MSG_READY_I, LOG_WR_O, LOG_VALID_O, LOG_UNCORR_O, LOG_UNSAFE_O, LOG_CONSUMED_O;
  logic LOG_SEVERAL_O, MSG_VALID_O, MSG_SEVERAL_O, MSG_UNCORR_O, MSG_UNSAFE_O;
  logic POISON_O, DISCARD_O, AER_REPORT_O, AER_UNCORR_O;
  logic [7:0] LOG_SRC_ID_O, MSG_SRC_ID_O, MSG_REVISION_O, got;
  logic [63:0] LOG_ADDR_O, MSG_ADDR_O, POISON_ADDR_O;
  logic [5:0] MSG_DEST_ID_O;
  logic [3:0] delay = '0;
  int num_errors = 0;
  int samples_checked = 0;

  prer_top i_dut (.*);
  prer_sink_model i_sink (.clk_i(CLOCK_I), .rst_i(RESET_I), .msg_valid_i(MSG_VALID_O),
    .delay_i(delay), .msg_ready_o(MSG_READY_I), .count_o(got));

  initial begin
    forever #20 CLOCK_I = ~CLOCK_I;
  end

  // --------------------------------
  // shared tasks
  // --------------------------------
  task chk(input logic [63:0] seen, input logic [63:0] want);
    samples_checked++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH t=%0t seen=%h want=%h", $time, seen, want);
    end
  endtask : chk

  // flags: transport uncorr ecc decode produced consumed poison_able unsafe
  task send(input logic [7:0] f, input logic [7:0] s);
    @(posedge CLOCK_I);
    ERR_VALID_I <= 1'b1;
    {ERR_TRANSPORT_I, ERR_UNCORR_I, ERR_ECC_I, ERR_DECODE_I, ERR_PRODUCED_I,
      ERR_CONSUMED_I, ERR_POISON_ABLE_I, ERR_UNSAFE_I} <= f;
    ERR_SRC_ID_I <= s;
    ERR_ADDR_I <= {s, 56'h34_5678_9ABC_DEF7};
    @(posedge CLOCK_I);
    ERR_VALID_I <= 1'b0;
    #1;
  endtask : send

  task clear(input logic m);
    @(posedge CLOCK_I);
    LOG_CLEAR_I <= 1'b1;
    REPORT_MASK_I <= m;
    @(posedge CLOCK_I);
    LOG_CLEAR_I <= 1'b0;
  endtask : clear

  // waits out the sink, then the message must be gone
  task drain;
    for (int i = 0; i < 40 && MSG_VALID_O === 1'b1; i++) begin
      @(posedge CLOCK_I);
      #1;
    end
    chk(MSG_VALID_O, 0);
  endtask : drain

  // --------------------------------
  // scenarios
  // --------------------------------
  task t_report(input logic [3:0] d, input logic [7:0] s);
    logic [7:0] n;
    n = got;
    clear(1'b0);
    ERROR_SINK_AGENT_ID_I <= s[5:0];
    delay <= d;
    send(8'h6A, s);
    chk(LOG_WR_O, 1);
    chk(LOG_SRC_ID_O, s);
    chk(LOG_VALID_O, 1);
    chk(LOG_UNCORR_O, 1);
    chk(LOG_ADDR_O, {s, 56'h34_5678_9ABC_DEF7});
    chk(POISON_O, 1);
    chk(POISON_ADDR_O, {s, 56'h34_5678_9ABC_DEC0});
    chk(MSG_VALID_O, 0);
    @(posedge CLOCK_I);
    #1;
    chk(MSG_VALID_O, 1);
    chk(MSG_DEST_ID_O, s[5:0]);
    chk(MSG_REVISION_O, 8'h01);
    chk(MSG_ADDR_O, {s, 56'h34_5678_9ABC_DEF7});
    chk(MSG_SRC_ID_O, s);
    chk(MSG_UNCORR_O, 1);
    chk(MSG_UNSAFE_O, 0);
    chk(MSG_SEVERAL_O, 0);
    for (int i = 0; i < 20 && MSG_VALID_O === 1'b1; i++) begin
      @(posedge CLOCK_I);
      #1;
    end
    chk(MSG_VALID_O, 0);
    chk(got, n + 8'h01);
    $display("report done");
  endtask : t_report

  task t_several;
    clear(1'b1);
    send(8'h20, 8'h33);
    chk(LOG_WR_O, 1);
    repeat (3) begin
      @(posedge CLOCK_I);
      #1;
      chk(MSG_VALID_O, 0);
    end
    send(8'h20, 8'h44);
    chk(LOG_WR_O, 0);
    @(posedge CLOCK_I);
    #1;
    chk(LOG_SEVERAL_O, 1);
    send(8'h60, 8'h55);
    chk(LOG_SRC_ID_O, 8'h55);
    send(8'h60, 8'h66);
    chk(LOG_WR_O, 0);
    chk(LOG_SRC_ID_O, 8'h55);
    $display("several done");
  endtask : t_several

  task t_aer;
    clear(1'b0);
    send(8'hE0, 8'h77);
    chk(AER_REPORT_O, 1);
    chk(AER_UNCORR_O, 1);
    chk(LOG_WR_O, 0);
    chk(LOG_VALID_O, 0);
    chk(LOG_SEVERAL_O, 0);
    send(8'h80, 8'h78);
    chk(AER_UNCORR_O, 0);
    chk(MSG_VALID_O, 0);
    // a reported corrected error, then an unpoisonable uncorrected one over it
    send(8'h20, 8'h79);
    @(posedge CLOCK_I);
    #1;
    chk(MSG_SEVERAL_O, 0);
    drain;
    send(8'h61, 8'h7A);
    chk(LOG_WR_O, 1);
    chk(LOG_SEVERAL_O, 1);
    chk(LOG_UNSAFE_O, 1);
    @(posedge CLOCK_I);
    #1;
    chk(MSG_VALID_O, 1);
    chk(MSG_SEVERAL_O, 1);
    chk(MSG_UNCORR_O, 1);
    chk(MSG_UNSAFE_O, 1);
    chk(MSG_SRC_ID_O, 8'h7A);
    drain;
    $display("aer done");
  endtask : t_aer

  task t_poison;
    clear(1'b1);
    send(8'h59, 8'h88);
    chk(LOG_UNSAFE_O, 1);
    chk(POISON_O, 0);
    clear(1'b1);
    send(8'h5E, 8'h99);
    chk(POISON_O, 1);
    chk(DISCARD_O, 1);
    chk(LOG_CONSUMED_O, 1);
    $display("poison done");
  endtask : t_poison

  // reset while a report waits at a slow sink, then an event right after
  task t_reset;
    clear(1'b0);
    delay <= 4'hF;
    send(8'h20, 8'hA5);
    @(posedge CLOCK_I);
    #1;
    chk(MSG_VALID_O, 1);
    @(posedge CLOCK_I);
    RESET_I <= 1'b1;
    repeat (2) @(posedge CLOCK_I);
    RESET_I <= 1'b0;
    delay <= 4'h0;
    #1;
    chk(MSG_VALID_O, 0);
    chk(LOG_VALID_O, 0);
    chk(MSG_REVISION_O, 8'h00);
    send(8'h20, 8'hA6);
    chk(LOG_WR_O, 1);
    chk(LOG_SRC_ID_O, 8'hA6);
    chk(LOG_SEVERAL_O, 0);
    @(posedge CLOCK_I);
    #1;
    chk(MSG_VALID_O, 1);
    chk(MSG_SRC_ID_O, 8'hA6);
    drain;
    $display("reset done");
  endtask : t_reset

  task report_and_stop;
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : report_and_stop

  initial begin
    repeat (16) @(posedge CLOCK_I);
    RESET_I <= 1'b0;
    t_report(4'h3, 8'h11);
    t_report(4'h0, 8'h22);
    t_several;
    t_aer;
    t_poison;
    t_reset;
    report_and_stop;
  end

  initial begin
    repeat (3000) @(posedge CLOCK_I);
    num_errors++;
    report_and_stop;
  end
endmodule : testbench

`default_nettype wire
